// ---- rtl/ebac_config.sv ----
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module ebac_config #(
    parameter int ADDR_W = 24
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic hwStandby,
    input wire logic swStandby,
    input wire logic [2:0] opMode,
    input wire logic mode16M,
    input wire logic [ADDR_W-1:0] accessAddr,
    input wire logic accessExternal,
    output logic [7:0] threeStateSelect,
    output logic [7:0] waitControllerEnable,
    output logic [1:0] waitModeSelect,
    output logic [1:0] waitCount,
    output logic [2:0] areaIdx,
    output ebac_pkg::ebac_wait_t areaWaitMode,
    output logic [1:0] areaProgWaits,
    output logic [1:0] areaAccessStates,
    output logic portAPin4IsAddr,
    output logic portAPin5IsAddr,
    output logic portAPin6IsAddr
);
    logic [7:0] areaAccessStates_r;
    logic [7:0] waitControl_r;
    logic [7:0] waitControllerEnables_r;
    logic [7:0] upperAddrPinControl_r;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    ebac_pkg::ebac_bus_t busState_r;
    logic busReq;
    logic busAccept;
    logic wrByte0;
    logic upperWritable;
    logic isExternal;
    logic [2:0] pinAddrEn;

    // bus request decode
    assign busReq = read || write;
    assign busAccept = busReq && (busState_r == ebac_pkg::BUS_ACK);
    assign waitrequest = busReq && (busState_r != ebac_pkg::BUS_ACK);
    assign wrByte0 = write && busAccept && byteenable[0];
    assign upperWritable = ebac_pkg::upperAddrMode(opMode);
    assign readdata = readdata_r;

    // one wait cycle per request, then the answer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busState_r <= ebac_pkg::BUS_IDLE;
        end else begin
            case (busState_r)
                ebac_pkg::BUS_IDLE: begin
                    if (busReq) begin
                        busState_r <= ebac_pkg::BUS_ACK;
                    end
                end
                ebac_pkg::BUS_ACK: begin
                    busState_r <= ebac_pkg::BUS_IDLE;
                end
                default: begin
                    busState_r <= ebac_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // read mux, unmapped words read zero
    always_comb begin
        readdata_nxt = 32'h0;
        case (address)
            ebac_pkg::OFS_AREA_STATES: readdata_nxt[7:0] = areaAccessStates_r;
            ebac_pkg::OFS_WAIT_CTRL: readdata_nxt[7:0] = waitControl_r | ebac_pkg::WAIT_CTRL_ONES;
            ebac_pkg::OFS_WAIT_ENABLES: readdata_nxt[7:0] = waitControllerEnables_r;
            ebac_pkg::OFS_UPPER_ADDR: readdata_nxt[7:0] = upperAddrPinControl_r | ebac_pkg::UPPER_ADDR_ONES;
            ebac_pkg::OFS_STATUS: readdata_nxt[7:0] = {2'h0, opMode, pinAddrEn};
            default: readdata_nxt = 32'h0;
        endcase
    end

    // read data captured in the wait cycle, stands at the answer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            readdata_r <= 32'h0;
        end else if (read && (busState_r == ebac_pkg::BUS_IDLE)) begin
            readdata_r <= readdata_nxt;
        end
    end

    // area access states; software standby holds the value
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            areaAccessStates_r <= ebac_pkg::RST_AREA_STATES;
        end else if (hwStandby) begin
            areaAccessStates_r <= ebac_pkg::RST_AREA_STATES;
        end else if (wrByte0 && (address == ebac_pkg::OFS_AREA_STATES)) begin
            areaAccessStates_r <= writedata[7:0];
        end
    end

    // wait control, upper nibble pinned to ones
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waitControl_r <= ebac_pkg::RST_WAIT_CTRL;
        end else if (hwStandby) begin
            waitControl_r <= ebac_pkg::RST_WAIT_CTRL;
        end else if (wrByte0 && (address == ebac_pkg::OFS_WAIT_CTRL)) begin
            waitControl_r <= writedata[7:0] | ebac_pkg::WAIT_CTRL_ONES;
        end
    end

    // per-area wait controller enables
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            waitControllerEnables_r <= ebac_pkg::RST_WAIT_ENABLES;
        end else if (hwStandby) begin
            waitControllerEnables_r <= ebac_pkg::RST_WAIT_ENABLES;
        end else if (wrByte0 && (address == ebac_pkg::OFS_WAIT_ENABLES)) begin
            waitControllerEnables_r <= writedata[7:0];
        end
    end

    // upper address control: top bits locked outside modes 3 and 6
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            upperAddrPinControl_r <= ebac_pkg::RST_UPPER_ADDR;
        end else if (hwStandby) begin
            upperAddrPinControl_r <= ebac_pkg::RST_UPPER_ADDR;
        end else if (wrByte0 && (address == ebac_pkg::OFS_UPPER_ADDR)) begin
            if (upperWritable) begin
                upperAddrPinControl_r[7:5] <= writedata[7:5];
            end
            upperAddrPinControl_r[4:1] <= 4'hf;
            upperAddrPinControl_r[ebac_pkg::ADR_BIT0_POS] <= writedata[ebac_pkg::ADR_BIT0_POS];
        end
    end

    // settings presented straight to the bus cycle logic
    assign threeStateSelect = areaAccessStates_r;
    assign waitControllerEnable = waitControllerEnables_r;
    assign waitModeSelect = waitControl_r[ebac_pkg::MODE_SEL_MSB:ebac_pkg::MODE_SEL_LSB];
    assign waitCount = waitControl_r[ebac_pkg::COUNT_MSB:ebac_pkg::COUNT_LSB];

    // pin function: in modes 3 and 6 a cleared enable bit routes address line 23/22/21
    assign pinAddrEn = upperWritable ? ~upperAddrPinControl_r[ebac_pkg::ADDR_EN_MSB:ebac_pkg::ADDR_EN_LSB]
        : 3'h0;
    assign portAPin4IsAddr = pinAddrEn[2];
    assign portAPin5IsAddr = pinAddrEn[1];
    assign portAPin6IsAddr = pinAddrEn[0];

    // single-chip mode has no external space at all
    assign isExternal = accessExternal && (opMode != ebac_pkg::MODE_SINGLE_CHIP);

    // area index of the current access
    ebac_area_decode #(
        .ADDR_W(ADDR_W)
    ) u_area_decode (
        .accessAddr(accessAddr),
        .mode16M(mode16M),
        .areaIdx(areaIdx)
    );

    // bus specification of the addressed area
    ebac_wait_select u_wait_select (
        .external(isExternal),
        .threeState(areaAccessStates_r[areaIdx]),
        .ctrlEnable(waitControllerEnables_r[areaIdx]),
        .waitModeSel(waitModeSelect),
        .waitCount(waitCount),
        .waitMode(areaWaitMode),
        .progWaits(areaProgWaits),
        .accessStates(areaAccessStates)
    );

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence seqStandbyInit;
        hwStandby;
    endsequence

    sequence seqAreaWrite;
        write && !waitrequest && byteenable[0] && (address == ebac_pkg::OFS_AREA_STATES) && !hwStandby;
    endsequence

    sequence seqUpperWriteLocked;
        write && !waitrequest && byteenable[0] && (address == ebac_pkg::OFS_UPPER_ADDR) && !upperWritable
            && !hwStandby;
    endsequence

    // accepted low-lane write to one register, standby not overriding it
    sequence seqWriteTo(logic [2:0] ofs);
        write && !waitrequest && byteenable[0] && (address == ofs) && !hwStandby;
    endsequence

    // read answered at this edge
    sequence seqReadFrom(logic [2:0] ofs);
        read && !waitrequest && (address == ofs);
    endsequence

    // external three-state access with the controller switched on
    sequence seqCtrlArea;
        isExternal && areaAccessStates_r[areaIdx] && waitControllerEnables_r[areaIdx];
    endsequence

    AST_STANDBY_INIT: assert property (seqStandbyInit |=> (areaAccessStates_r == 8'hff) && (waitControl_r == 8'hf3)
        && (waitControllerEnables_r == 8'hff) && (upperAddrPinControl_r == 8'hfe))
        else $error("standby did not restore register values");

    AST_AREA_WRITE: assert property (seqAreaWrite |=> (threeStateSelect == $past(writedata[7:0])))
        else $error("area states write not taken");

    AST_WAIT_UPPER: assert property (seqReadFrom(ebac_pkg::OFS_WAIT_CTRL) |-> (readdata[7:4] == 4'hf))
        else $error("wait control upper nibble not ones");

    AST_UPPER_RSV: assert property (upperAddrPinControl_r[4:1] == 4'hf)
        else $error("upper address reserved bits changed");

    AST_UPPER_LOCK: assert property (seqUpperWriteLocked |=> $stable(upperAddrPinControl_r[7:5]))
        else $error("upper address enables changed in locked mode");

    AST_PIN_ROUTE: assert property (portAPin4IsAddr |-> upperWritable && !upperAddrPinControl_r[7])
        else $error("pin routed to address without enable");

    AST_TWO_STATE: assert property (isExternal && !areaAccessStates_r[areaIdx]
        |-> (areaAccessStates == 2'h2) && (areaProgWaits == 2'h0) && (areaWaitMode == ebac_pkg::WAIT_NONE))
        else $error("two-state area got wait states");

    AST_SINGLE_CHIP: assert property ((opMode == ebac_pkg::MODE_SINGLE_CHIP)
        |-> (areaWaitMode == ebac_pkg::WAIT_NONE) && (areaAccessStates == 2'h2))
        else $error("single chip mode affected by area settings");

    AST_PROG_COUNT: assert property (isExternal && areaAccessStates_r[areaIdx] && waitControllerEnables_r[areaIdx]
        && (waitModeSelect == 2'h0) |-> (areaProgWaits == waitCount) && (areaWaitMode == ebac_pkg::WAIT_PROG))
        else $error("programmable wait count not applied");

    AST_PIN0: assert property (isExternal && areaAccessStates_r[areaIdx] && !waitControllerEnables_r[areaIdx]
        |-> (areaWaitMode == ebac_pkg::WAIT_PIN0) && (areaAccessStates == 2'h3))
        else $error("disabled controller not in pin wait mode 0");

    AST_NOWAIT: assert property (isExternal && areaAccessStates_r[areaIdx] && waitControllerEnables_r[areaIdx]
        && (waitModeSelect == 2'h1) |-> (areaWaitMode == ebac_pkg::WAIT_NONE))
        else $error("no-wait mode inserted waits");

    AST_BUS_ANSWER: assert property ((busReq && waitrequest) |=> !waitrequest || !busReq)
        else $error("slave held waitrequest over one cycle");

    AST_SW_STANDBY: assert property (swStandby && !hwStandby && !write
        |=> $stable(areaAccessStates_r) && $stable(waitControl_r))
        else $error("software standby altered registers");

    AST_WAIT_WRITE: assert property (seqWriteTo(ebac_pkg::OFS_WAIT_CTRL)
        |=> (waitModeSelect == $past(writedata[3:2])) && (waitCount == $past(writedata[1:0])))
        else $error("wait control write not taken");

    AST_ENABLE_WRITE: assert property (seqWriteTo(ebac_pkg::OFS_WAIT_ENABLES)
        |=> (waitControllerEnable == $past(writedata[7:0])))
        else $error("wait controller enable write not taken");

    AST_UPPER_OPEN: assert property (seqWriteTo(ebac_pkg::OFS_UPPER_ADDR) ##0 upperWritable
        |=> (upperAddrPinControl_r[7:5] == $past(writedata[7:5])))
        else $error("upper address enables not written in open mode");

    AST_UPPER_BIT0: assert property (seqWriteTo(ebac_pkg::OFS_UPPER_ADDR)
        |=> (upperAddrPinControl_r[0] == $past(writedata[0])))
        else $error("upper address bit 0 not stored");

    AST_UPPER_READ: assert property (seqReadFrom(ebac_pkg::OFS_UPPER_ADDR) |-> (readdata[4:1] == 4'hf))
        else $error("upper address reserved bits not read as ones");

    AST_AREA_READ: assert property (seqReadFrom(ebac_pkg::OFS_AREA_STATES)
        |-> (readdata[7:0] == areaAccessStates_r))
        else $error("area states read back wrong");

    AST_PIN5_ROUTE: assert property (portAPin5IsAddr |-> upperWritable && !upperAddrPinControl_r[6])
        else $error("pin 5 routed to address without enable");

    AST_PIN6_ROUTE: assert property (portAPin6IsAddr |-> upperWritable && !upperAddrPinControl_r[5])
        else $error("pin 6 routed to address without enable");

    AST_PIN_OPEN: assert property (upperWritable && !upperAddrPinControl_r[7] |-> portAPin4IsAddr)
        else $error("cleared enable did not route pin 4");

    AST_THREE_STATE: assert property (isExternal && areaAccessStates_r[areaIdx]
        |-> (areaAccessStates == 2'h3))
        else $error("three-state area not given three states");

    AST_PIN1: assert property (seqCtrlArea ##0 (waitModeSelect == 2'h2)
        |-> (areaWaitMode == ebac_pkg::WAIT_PIN1))
        else $error("pin wait mode 1 not selected");

    AST_AUTO: assert property (seqCtrlArea ##0 (waitModeSelect == 2'h3)
        |-> (areaWaitMode == ebac_pkg::WAIT_AUTO))
        else $error("pin auto-wait mode not selected");

    AST_SW_KEEP: assert property (swStandby && !hwStandby && !write
        |=> $stable(waitControllerEnables_r) && $stable(upperAddrPinControl_r))
        else $error("software standby altered enables or address control");
endmodule : ebac_config

// ---- rtl/ebac_pkg.sv ----
// Contract
// - per-area bit: 0 two states, 1 three
// - area states reg resets/standby-inits to all ones
// - on-chip accesses ignore it; mode 7 meaningless
// - wait control resets/standby-inits to 0xf3
// - wait control upper nibble fixed, reads ones
// - wait mode field bits 3:2 selects mode
// - wait count bits 1:0 gives zero-three waits
// - per-area enable: 0 pin wait mode 0
// - controller enables reset/standby-init to all ones
// - enables act only on external three-state areas
// - upper address control resets/standby-inits to 0xfe
// - in modes 3, 6 cleared bits 7:5 route address 23:21 to pins
// - those bits writable only in modes 3, 6
// - two-state areas never get wait states
// - eight equal areas, 128 kbytes or 2 Mbytes
package ebac_pkg;
    // register word offsets (word address on the slave port)
    localparam logic [2:0] OFS_AREA_STATES = 3'h0;
    localparam logic [2:0] OFS_WAIT_CTRL = 3'h1;
    localparam logic [2:0] OFS_WAIT_ENABLES = 3'h2;
    localparam logic [2:0] OFS_UPPER_ADDR = 3'h3;
    localparam logic [2:0] OFS_STATUS = 3'h4;
    // values after reset and hardware standby
    localparam logic [7:0] RST_AREA_STATES = 8'hff;
    localparam logic [7:0] RST_WAIT_CTRL = 8'hf3;
    localparam logic [7:0] RST_WAIT_ENABLES = 8'hff;
    localparam logic [7:0] RST_UPPER_ADDR = 8'hfe;
    // fixed-one masks of the mixed registers
    localparam logic [7:0] WAIT_CTRL_ONES = 8'hf0;
    localparam logic [7:0] UPPER_ADDR_ONES = 8'h1e;
    // field positions
    localparam int MODE_SEL_MSB = 3;
    localparam int MODE_SEL_LSB = 2;
    localparam int COUNT_MSB = 1;
    localparam int COUNT_LSB = 0;
    localparam int ADDR_EN_MSB = 7;
    localparam int ADDR_EN_LSB = 5;
    localparam int ADR_BIT0_POS = 0;
    // area index bits of the access address
    localparam int AREA_LSB_1M = 17;
    localparam int AREA_LSB_16M = 21;
    // access state counts
    localparam logic [1:0] STATES_TWO = 2'h2;
    localparam logic [1:0] STATES_THREE = 2'h3;
    // operating modes
    localparam logic [2:0] MODE_SINGLE_CHIP = 3'h7;
    localparam logic [2:0] MODE_UPPER_A = 3'h3;
    localparam logic [2:0] MODE_UPPER_B = 3'h6;
    // wait mode field encodings
    typedef enum logic [1:0] {
        SEL_PROG = 2'h0,
        SEL_NOWAIT = 2'h1,
        SEL_PIN1 = 2'h2,
        SEL_AUTO = 2'h3
    } ebac_modesel_t;
    // effective wait behaviour seen by the bus cycle logic
    typedef enum logic [2:0] {
        WAIT_NONE = 3'h0,
        WAIT_PIN0 = 3'h1,
        WAIT_PROG = 3'h2,
        WAIT_PIN1 = 3'h3,
        WAIT_AUTO = 3'h4
    } ebac_wait_t;
    // slave handshake states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'h0,
        BUS_ACK = 1'h1
    } ebac_bus_t;
    // modes in which the upper address lines may be enabled
    function automatic logic upperAddrMode(input logic [2:0] mode);
        upperAddrMode = (mode == MODE_UPPER_A) || (mode == MODE_UPPER_B);
    endfunction : upperAddrMode
endpackage : ebac_pkg

// ---- rtl/ebac_area_decode.sv ----
`timescale 1ns/1ps
module ebac_area_decode #(
    parameter int ADDR_W = 24
) (
    input wire logic [ADDR_W-1:0] accessAddr,
    input wire logic mode16M,
    output logic [2:0] areaIdx
);
    // eight equal areas: 128 kbyte or 2 Mbyte slices
    always_comb begin
        if (mode16M) begin
            areaIdx = accessAddr[ebac_pkg::AREA_LSB_16M +: 3];
        end else begin
            areaIdx = accessAddr[ebac_pkg::AREA_LSB_1M +: 3];
        end
    end
endmodule : ebac_area_decode

// ---- rtl/ebac_wait_select.sv ----
`timescale 1ns/1ps
module ebac_wait_select (
    input wire logic external,
    input wire logic threeState,
    input wire logic ctrlEnable,
    input wire logic [1:0] waitModeSel,
    input wire logic [1:0] waitCount,
    output ebac_pkg::ebac_wait_t waitMode,
    output logic [1:0] progWaits,
    output logic [1:0] accessStates
);
    // per-access wait behaviour from area bits and wait control
    always_comb begin
        waitMode = ebac_pkg::WAIT_NONE;
        progWaits = 2'h0;
        accessStates = ebac_pkg::STATES_TWO;
        if (!external) begin
            // on-chip targets keep their own fixed timing
            accessStates = ebac_pkg::STATES_TWO;
        end else if (!threeState) begin
            accessStates = ebac_pkg::STATES_TWO;
        end else if (!ctrlEnable) begin
            accessStates = ebac_pkg::STATES_THREE;
            waitMode = ebac_pkg::WAIT_PIN0;
        end else begin
            accessStates = ebac_pkg::STATES_THREE;
            case (waitModeSel)
                ebac_pkg::SEL_PROG: begin
                    waitMode = ebac_pkg::WAIT_PROG;
                    progWaits = waitCount;
                end
                ebac_pkg::SEL_NOWAIT: begin
                    waitMode = ebac_pkg::WAIT_NONE;
                end
                ebac_pkg::SEL_PIN1: begin
                    waitMode = ebac_pkg::WAIT_PIN1;
                    progWaits = waitCount;
                end
                ebac_pkg::SEL_AUTO: begin
                    waitMode = ebac_pkg::WAIT_AUTO;
                    progWaits = waitCount;
                end
                default: begin
                    waitMode = ebac_pkg::WAIT_NONE;
                end
            endcase
        end
    end
endmodule : ebac_wait_select

// ---- verification/ebac_ext_model.sv ----
`timescale 1ns/1ps
module ebac_ext_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [2:0] reqArea,
    input wire logic reqExternal,
    input wire logic mode16M,
    output logic [23:0] accessAddr,
    output logic accessExternal
);
    logic [16:0] ofs_r;
    // low address bits wander every cycle so only the area field may matter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ofs_r <= 17'h0;
        end else begin
            ofs_r <= ofs_r + 17'h0b3d5;
        end
    end
    // area field placed by memory size, eight equal areas
    always_comb begin
        if (mode16M) begin
            accessAddr = {reqArea, 4'h0, ofs_r};
        end else begin
            accessAddr = {4'h0, reqArea, ofs_r};
        end
        accessExternal = reqExternal;
    end
endmodule : ebac_ext_model

// ---- verification/external_bus_area_config_tb.sv ----
`timescale 1ns/1ps
module external_bus_area_config_tb;
    logic core_clk, nrst, read, write, waitrequest, hwStandby, swStandby, mode16M, reqExternal, accessExternal;
    logic [2:0] address, opMode, reqArea, areaIdx;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic [23:0] accessAddr;
    logic [7:0] threeStateSelect, waitControllerEnable;
    logic [1:0] waitModeSelect, waitCount, areaProgWaits, areaAccessStates;
    ebac_pkg::ebac_wait_t areaWaitMode;
    logic pin4, pin5, pin6;
    int nMismatch = 0;
    int testsRun = 0;
    int cycles = 0;
    ebac_config u_ebac_config (.core_clk(core_clk), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .hwStandby(hwStandby), .swStandby(swStandby), .opMode(opMode), .mode16M(mode16M),
        .accessAddr(accessAddr), .accessExternal(accessExternal), .threeStateSelect(threeStateSelect),
        .waitControllerEnable(waitControllerEnable), .waitModeSelect(waitModeSelect), .waitCount(waitCount),
        .areaIdx(areaIdx), .areaWaitMode(areaWaitMode), .areaProgWaits(areaProgWaits),
        .areaAccessStates(areaAccessStates), .portAPin4IsAddr(pin4), .portAPin5IsAddr(pin5),
        .portAPin6IsAddr(pin6));
    ebac_ext_model u_ebac_ext_model (.core_clk(core_clk), .nrst(nrst), .reqArea(reqArea),
        .reqExternal(reqExternal), .mode16M(mode16M), .accessAddr(accessAddr), .accessExternal(accessExternal));
    // clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // cuts a hang short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            nMismatch++;
            $display("unexpected at %0t: run exceeded cycle limit", $time);
            close_out();
        end
    end
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", nMismatch, testsRun);
        if (nMismatch == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one slave access, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge core_clk);
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= 4'h1;
        write <= wr;
        read <= ~wr;
        // request held until the edge at which waitrequest is seen low
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h0, q);
        chk(q, {24'h0, e});
    endtask : rd
    // presents one access to the decode and lets it settle
    task automatic look(input logic [2:0] area, input logic ext);
        @(posedge core_clk);
        reqArea <= area;
        reqExternal <= ext;
        mode16M <= area[0];
        @(posedge core_clk);
    endtask : look
    task automatic seen(input ebac_pkg::ebac_wait_t m, input logic [1:0] w, input logic [1:0] s);
        chk({29'h0, areaWaitMode}, {29'h0, m});
        chk({30'h0, areaProgWaits}, {30'h0, w});
        chk({30'h0, areaAccessStates}, {30'h0, s});
    endtask : seen
    task automatic t_reset();
        rd(3'h0, 8'hff);
        rd(3'h1, 8'hf3);
        rd(3'h2, 8'hff);
        rd(3'h3, 8'hfe);
        rd(3'h5, 8'h00);
    endtask : t_reset
    task automatic t_wait();
        ebac_pkg::ebac_wait_t em [4] = '{ebac_pkg::WAIT_PROG, ebac_pkg::WAIT_NONE, ebac_pkg::WAIT_PIN1,
            ebac_pkg::WAIT_AUTO};
        logic [1:0] c;
        wr(3'h1, 8'h00);
        rd(3'h1, 8'hf0);
        for (int m = 0; m < 4; m++) begin
            c = 2'(m) ^ 2'h1;
            wr(3'h1, {4'h0, 2'(m), c});
            look(3'h1, 1'b1);
            seen(em[m], (m == 1) ? 2'h0 : c, ebac_pkg::STATES_THREE);
        end
    endtask : t_wait
    task automatic t_areas();
        wr(3'h1, 8'h01);
        wr(3'h0, 8'h0f);
        for (int a = 0; a < 8; a++) begin
            look(3'(a), 1'b1);
            chk({29'h0, areaIdx}, 32'(a));
            if (a < 4) begin
                seen(ebac_pkg::WAIT_PROG, 2'h1, ebac_pkg::STATES_THREE);
            end else begin
                seen(ebac_pkg::WAIT_NONE, 2'h0, ebac_pkg::STATES_TWO);
            end
        end
        wr(3'h2, 8'h1e);
        look(3'h0, 1'b1);
        seen(ebac_pkg::WAIT_PIN0, 2'h0, ebac_pkg::STATES_THREE);
        look(3'h4, 1'b1);
        seen(ebac_pkg::WAIT_NONE, 2'h0, ebac_pkg::STATES_TWO);
        look(3'h1, 1'b0);
        seen(ebac_pkg::WAIT_NONE, 2'h0, ebac_pkg::STATES_TWO);
        opMode <= 3'h7;
        look(3'h1, 1'b1);
        seen(ebac_pkg::WAIT_NONE, 2'h0, ebac_pkg::STATES_TWO);
        opMode <= 3'h5;
    endtask : t_areas
    task automatic pins(input logic [2:0] e);
        @(posedge core_clk);
        chk({29'h0, pin4, pin5, pin6}, {29'h0, e});
    endtask : pins
    task automatic t_upper();
        wr(3'h3, 8'h01);
        rd(3'h3, 8'hff);
        wr(3'h3, 8'h00);
        rd(3'h3, 8'hfe);
        pins(3'h0);
        opMode <= 3'h3;
        wr(3'h3, 8'h00);
        rd(3'h3, 8'h1e);
        pins(3'h7);
        wr(3'h3, 8'ha0);
        rd(3'h3, 8'hbe);
        pins(3'h2);
        opMode <= 3'h6;
        pins(3'h2);
        rd(3'h4, 8'h32);
        opMode <= 3'h1;
        pins(3'h0);
    endtask : t_upper
    task automatic t_standby();
        wr(3'h0, 8'h5a);
        wr(3'h2, 8'ha5);
        swStandby <= 1'b1;
        rd(3'h0, 8'h5a);
        rd(3'h2, 8'ha5);
        rd(3'h1, 8'hf1);
        swStandby <= 1'b0;
        hwStandby <= 1'b1;
        @(posedge core_clk);
        hwStandby <= 1'b0;
        t_reset();
        // reset in mid-run restores the values after a write
        wr(3'h0, 8'h3c);
        nrst <= 1'b0;
        @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
    endtask : t_standby
    initial begin
        nrst = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 3'h0;
        writedata = 32'h0;
        byteenable = 4'h0;
        hwStandby = 1'b0;
        swStandby = 1'b0;
        opMode = 3'h5;
        mode16M = 1'b0;
        reqArea = 3'h0;
        reqExternal = 1'b0;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_wait();
        t_areas();
        t_upper();
        t_standby();
        close_out();
    end
endmodule : external_bus_area_config_tb
